//--- ebh_dev.sv
// Bus controller end: ready-controlled bus cycles, hold arbitration, AHB-Lite registers.
`timescale 1ns/10ps
// Function
// - Selectable ready input polarity.
// - Synchronous ready driven with reference clock.
// - Asynchronous ready passes extra synchroniser stage.
// - Asynchronous ready held one period plus setup.
// - Ready may drop on strobe rising edge.
// - Ready inactive before next cycle's sample.
// - Inactive ready inserts one waitstate, resample.
// - Active ready ends current bus cycle.
// - Asynchronous sampling point falls later than synchronous.
// - Hold honoured only when arbitration enabled.
// - Finish running cycle before hold acknowledge.
// - Release: drive strobes inactive, then float.
// - Regain: drive strobes inactive before own cycle.
// - Regain starts only when hold goes high.
// - Hold may drop without bus request.
// - Bus request only after hold acknowledge.
// - Own cycle may start after regain.
// - Read data captured on strobe rising edge.
// - External data may change after strobe rises.
module ebh_dev
    import ebh_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    ebh_if.dev link
);
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [EBH_CTRL_W-1:0] ctrl_reg;
    logic [EBH_AW-1:0] cmd_addr_reg;
    logic cmd_write_reg;
    logic [EBH_DW-1:0] wdata_reg;
    logic [EBH_DW-1:0] rdata_reg;
    logic pending_reg;
    logic [7:0] wait_cnt_reg;
    logic wr_phase_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_mux;
    logic cmd_wr;
    logic addr_ok;

    ebh_state_e state_reg;
    ebh_state_e state_next;
    logic [EBH_CNT_W-1:0] acc_cnt_reg;
    logic rdy_async;
    logic rdy_level;
    logic rdy_active;
    logic cycle_end;

    logic rdy_en;
    logic rdy_mode_async;
    logic rdy_pol;
    logic arb_en;
    logic [EBH_CNT_W-1:0] acc_len;

    assign rdy_en = ctrl_reg[EBH_CTRL_RDY_EN];
    assign rdy_mode_async = ctrl_reg[EBH_CTRL_RDY_ASYNC];
    assign rdy_pol = ctrl_reg[EBH_CTRL_RDY_POL];
    assign arb_en = ctrl_reg[EBH_CTRL_ARB_EN];
    assign acc_len = ctrl_reg[EBH_CTRL_ACC_LSB +: EBH_CNT_W];

    // The slave never stalls, so every transfer completes in one data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            EBH_OFS_CTRL: rd_mux = {23'h000000, ctrl_reg};
            EBH_OFS_CMD: rd_mux = {15'h0000, cmd_write_reg, cmd_addr_reg};
            EBH_OFS_WDATA: rd_mux = {16'h0000, wdata_reg};
            EBH_OFS_STATUS: begin
                rd_mux[EBH_ST_PEND] = pending_reg;
                rd_mux[EBH_ST_HELD] = (state_reg == ST_HELD);
                rd_mux[EBH_ST_BUS_REQUEST_OUT] = !link.bus_request_out_n;
                rd_mux[EBH_ST_WAIT_LSB +: 8] = wait_cnt_reg;
            end
            EBH_OFS_RDATA: rd_mux = {16'h0000, rdata_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_phase_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // A command written while one is still pending is dropped.
    assign cmd_wr = wr_phase_reg && (wr_addr_reg == EBH_OFS_CMD) && !pending_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= EBH_CTRL_RST;
            cmd_addr_reg <= '0;
            cmd_write_reg <= 1'b0;
            wdata_reg <= '0;
        end else if (wr_phase_reg) begin
            if (wr_addr_reg == EBH_OFS_CTRL) begin
                ctrl_reg <= hwdata[EBH_CTRL_W-1:0];
            end
            if (wr_addr_reg == EBH_OFS_WDATA) begin
                wdata_reg <= hwdata[EBH_DW-1:0];
            end
            if (cmd_wr) begin
                cmd_addr_reg <= hwdata[EBH_AW-1:0];
                cmd_write_reg <= hwdata[EBH_CMD_WRITE];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_reg <= 1'b0;
        end else if (cmd_wr) begin
            pending_reg <= 1'b1;
        end else if (cycle_end) begin
            pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Ready sampling
    // ----------------------------------------------------------------
    // The asynchronous path costs two cycles but tolerates any input timing.
    ebh_sync u_rdy_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .din(link.ready),
        .dout(rdy_async)
    );

    assign rdy_level = rdy_mode_async ? rdy_async : link.ready;
    assign rdy_active = (rdy_level == rdy_pol);

    // ----------------------------------------------------------------
    // Cycle and arbitration sequencer
    // ----------------------------------------------------------------
    assign link.bus_reference_clock_out = hclk;

    always_comb begin
        state_next = state_reg;
        cycle_end = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (arb_en && !link.hold_n) begin
                    state_next = ST_REL;
                end else if (pending_reg) begin
                    state_next = ST_ADDR;
                end
            end
            ST_ADDR: state_next = ST_ACC;
            ST_ACC: begin
                if (acc_cnt_reg == '0) begin
                    if (rdy_en) begin
                        state_next = ST_RDY;
                    end else begin
                        state_next = ST_IDLE;
                        cycle_end = 1'b1;
                    end
                end
            end
            ST_RDY: begin
                if (rdy_active) begin
                    state_next = ST_IDLE;
                    cycle_end = 1'b1;
                end
            end
            ST_REL: state_next = ST_HELD;
            ST_HELD: begin
                if (link.hold_n) begin
                    state_next = ST_REGAIN;
                end
            end
            ST_REGAIN: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_cnt_reg <= '0;
        end else if (state_reg == ST_ADDR) begin
            acc_cnt_reg <= acc_len;
        end else if (state_reg == ST_ACC && acc_cnt_reg != '0) begin
            acc_cnt_reg <= acc_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt_reg <= EBH_WAIT_RST;
        end else if (state_reg == ST_ADDR) begin
            wait_cnt_reg <= EBH_WAIT_RST;
        end else if (state_reg == ST_RDY && !rdy_active && wait_cnt_reg != 8'hff) begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
        end
    end

    // Read data lands on the edge that raises the strobe.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= '0;
        end else if (cycle_end && !cmd_write_reg) begin
            rdata_reg <= link.rdata;
        end
    end

    // ----------------------------------------------------------------
    // Link outputs
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.addr <= '0;
            link.wdata <= '0;
        end else if (state_next == ST_ADDR && state_reg == ST_IDLE) begin
            link.addr <= cmd_addr_reg;
            link.wdata <= wdata_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.ale <= 1'b0;
            link.rd_n_drv <= 1'b1;
            link.wr_n_drv <= 1'b1;
            link.rd_n_oe <= 1'b1;
            link.wr_n_oe <= 1'b1;
        end else begin
            link.ale <= (state_next == ST_ADDR);
            link.rd_n_drv <= !((state_next == ST_ACC || state_next == ST_RDY)
                && !cmd_write_reg);
            link.wr_n_drv <= !((state_next == ST_ACC || state_next == ST_RDY)
                && cmd_write_reg);
            link.rd_n_oe <= (state_next != ST_HELD);
            link.wr_n_oe <= (state_next != ST_HELD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.hold_acknowledge_out_n <= 1'b1;
            link.bus_request_out_n <= 1'b1;
        end else begin
            link.hold_acknowledge_out_n <= (state_next != ST_HELD);
            link.bus_request_out_n <= !(state_reg == ST_HELD && state_next == ST_HELD
                && pending_reg);
        end
    end
endmodule

//--- ebh_ext.sv
// External end: ready-controlled memory and alternate bus master hold requester.
`timescale 1ns/10ps
module ebh_ext
    import ebh_pkg::*;
(
    input wire logic rst_n,
    input wire logic [EBH_CNT_W-1:0] wait_cycles,
    input wire logic ready_pol,
    input wire logic hold_req,
    output logic bus_granted,
    output logic bus_wanted,
    ebh_if.ext link
);
    logic [EBH_DW-1:0] mem_reg [2**EBH_MEM_AW];
    logic [EBH_CNT_W-1:0] wait_reg;
    logic strobe_d_reg;
    logic rdy_on_reg;
    logic strobe;

    assign strobe = !link.rd_n || !link.wr_n;

    // Ready is timed from the reference clock, so it also serves the synchronous mode.
    always_ff @(posedge link.bus_reference_clock_out or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d_reg <= 1'b0;
            wait_reg <= '0;
            rdy_on_reg <= 1'b0;
        end else begin
            strobe_d_reg <= strobe;
            if (strobe && !strobe_d_reg) begin
                wait_reg <= wait_cycles;
                rdy_on_reg <= 1'b0;
            end else if (!strobe) begin
                rdy_on_reg <= 1'b0;
            end else if (wait_reg != '0) begin
                wait_reg <= wait_reg - 1'b1;
            end else begin
                rdy_on_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge link.bus_reference_clock_out or negedge rst_n) begin
        if (!rst_n) begin
            link.ready <= 1'b0;
        end else begin
            link.ready <= (rdy_on_reg && strobe) ? ready_pol : !ready_pol;
        end
    end

    // Memory writes land the edge after either strobe rises, a read cycle included; read data follows the address.
    always_ff @(posedge link.bus_reference_clock_out) begin
        if (strobe_d_reg && !strobe && link.rd_n) begin
            mem_reg[link.addr[EBH_MEM_AW-1:0]] <= link.wdata;
        end
    end

    always_ff @(posedge link.bus_reference_clock_out or negedge rst_n) begin
        if (!rst_n) begin
            link.rdata <= '0;
        end else begin
            link.rdata <= mem_reg[link.addr[EBH_MEM_AW-1:0]];
        end
    end

    always_ff @(posedge link.bus_reference_clock_out or negedge rst_n) begin
        if (!rst_n) begin
            link.hold_n <= 1'b1;
            bus_granted <= 1'b0;
            bus_wanted <= 1'b0;
        end else begin
            link.hold_n <= !hold_req;
            bus_granted <= !link.hold_acknowledge_out_n;
            bus_wanted <= !link.bus_request_out_n;
        end
    end
endmodule

//--- ebh_if.sv
// Link between the bus controller and the external circuit and alternate master.
`timescale 1ns/10ps
interface ebh_if;
    import ebh_pkg::*;
    logic bus_reference_clock_out;
    logic [EBH_AW-1:0] addr;
    logic [EBH_DW-1:0] wdata;
    logic [EBH_DW-1:0] rdata;
    logic ale;
    logic rd_n_drv;
    logic rd_n_oe;
    logic wr_n_drv;
    logic wr_n_oe;
    logic rd_n;
    logic wr_n;
    logic ready;
    logic hold_n;
    logic hold_acknowledge_out_n;
    logic bus_request_out_n;

    // Undriven strobes float to the weak pull-up level.
    assign rd_n = rd_n_oe ? rd_n_drv : 1'b1;
    assign wr_n = wr_n_oe ? wr_n_drv : 1'b1;

    modport dev (
        output bus_reference_clock_out, addr, wdata, ale,
        output rd_n_drv, rd_n_oe, wr_n_drv, wr_n_oe,
        output hold_acknowledge_out_n, bus_request_out_n,
        input rdata, ready, hold_n
    );
    modport ext (
        input bus_reference_clock_out, addr, wdata, ale, rd_n, wr_n,
        input hold_acknowledge_out_n, bus_request_out_n,
        output rdata, ready, hold_n
    );
endinterface

//--- ebh_pkg.sv
// Shared constants for the external bus ready and hold arbitration block.
package ebh_pkg;
    // ----------------------------------------------------------------
    // Link widths
    // ----------------------------------------------------------------
    localparam int EBH_AW = 16;
    localparam int EBH_DW = 16;
    localparam int EBH_MEM_AW = 4;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] EBH_OFS_CTRL = 8'h00;
    localparam logic [7:0] EBH_OFS_CMD = 8'h04;
    localparam logic [7:0] EBH_OFS_WDATA = 8'h08;
    localparam logic [7:0] EBH_OFS_STATUS = 8'h0c;
    localparam logic [7:0] EBH_OFS_RDATA = 8'h10;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int EBH_CTRL_RDY_EN = 0;
    localparam int EBH_CTRL_RDY_ASYNC = 1;
    localparam int EBH_CTRL_RDY_POL = 2;
    localparam int EBH_CTRL_ARB_EN = 3;
    localparam int EBH_CTRL_ACC_LSB = 4;
    localparam int EBH_CTRL_W = 9;
    localparam logic [8:0] EBH_CTRL_RST = 9'h000;

    // Command register: write bit above the address.
    localparam int EBH_CMD_WRITE = 16;

    // Status field positions.
    localparam int EBH_ST_PEND = 0;
    localparam int EBH_ST_HELD = 1;
    localparam int EBH_ST_BUS_REQUEST_OUT = 2;
    localparam int EBH_ST_WAIT_LSB = 8;

    // ----------------------------------------------------------------
    // Counts
    // ----------------------------------------------------------------
    localparam int EBH_CNT_W = 5;
    localparam logic [7:0] EBH_WAIT_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACC,
        ST_RDY,
        ST_REL,
        ST_HELD,
        ST_REGAIN
    } ebh_state_e;
endpackage

//--- ebh_sva.sv
// Link checker for the bus controller and external end pair.
`timescale 1ns/10ps
module ebh_sva
    import ebh_pkg::*;
(
    input wire logic bus_reference_clock_out,
    input wire logic hresetn,
    input wire logic [EBH_AW-1:0] addr,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic rd_n_oe,
    input wire logic wr_n_oe,
    input wire logic hold_n,
    input wire logic hold_acknowledge_out_n,
    input wire logic bus_request_out_n
);
    // ----------------------------------------------------------------
    // Bus cycle and arbitration properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge bus_reference_clock_out); endclocking
    default disable iff (!hresetn);

    a_ale_then_strobe: assert property (
        ale |=> !ale && (!rd_n || !wr_n)) else $error("strobe missing after ale");
    a_strobe_addr_kept: assert property (
        (!rd_n || !wr_n) |-> $stable(addr)) else $error("address moved under strobe");
    a_grant_after_cycle: assert property (
        $fell(hold_acknowledge_out_n) |-> $past(rd_n, 2) && $past(wr_n, 2))
        else $error("grant while a cycle ran");
    a_release_order: assert property (
        $fell(hold_acknowledge_out_n) |-> !rd_n_oe && !wr_n_oe && $past(rd_n_oe)
        && $past(wr_n_oe) && $past(rd_n) && $past(wr_n)) else $error("bad release order");
    a_held_floats: assert property (
        !hold_acknowledge_out_n |-> !rd_n_oe && !wr_n_oe && !ale && rd_n && wr_n)
        else $error("strobes driven while held");
    a_regain_drive: assert property (
        $rose(hold_acknowledge_out_n) |-> rd_n_oe && wr_n_oe && rd_n && wr_n && !ale
        && bus_request_out_n ##1 !ale) else $error("bad regain sequence");
    a_regain_cause: assert property (
        $rose(hold_acknowledge_out_n) |-> $past(hold_n)) else $error("regain without release");
    a_regain_prompt: assert property (
        !hold_acknowledge_out_n && hold_n |=> hold_acknowledge_out_n)
        else $error("hold withdrawal ignored");
    a_bus_request_out_when_held: assert property (
        !bus_request_out_n |-> !hold_acknowledge_out_n) else $error("request while owning bus");
    a_bus_request_out_after_ack: assert property (
        $fell(bus_request_out_n) |-> !$past(hold_acknowledge_out_n))
        else $error("request before acknowledge");

    c_grant: cover property ($fell(hold_acknowledge_out_n));
    c_regain: cover property ($rose(hold_acknowledge_out_n));
    c_bus_request_out: cover property ($fell(bus_request_out_n));
endmodule

//--- ebh_sync.sv
// Two-stage level synchroniser.
`timescale 1ns/10ps
module ebh_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

//--- ebh_tb_top.sv
// Self-checking bench for the bus controller and external end pair.
`timescale 1ns/10ps
module ebh_tb_top;
    import ebh_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    typedef struct {logic [8:0] ctrl; logic pol; logic [4:0] w; logic [7:0] waits;} ebh_row_s;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hold_req, ready_pol;
    logic bus_granted, bus_wanted;
    logic [31:0] haddr, hwdata, hrdata, rd_val;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [EBH_CNT_W-1:0] wait_cycles;
    int n_fail, cmp_count;
    // Expected waits with ready enabled and matching polarity: sync max(0, w + 2 - acc), since the far end registers ready twice.
    // Async adds two more for the synchroniser.
    ebh_row_s rows[7] = '{
        '{9'h005, 1'b1, 5'h00, 8'h02},
        '{9'h005, 1'b1, 5'h03, 8'h05},
        '{9'h001, 1'b0, 5'h02, 8'h04},
        '{9'h007, 1'b1, 5'h00, 8'h04},
        '{9'h025, 1'b1, 5'h03, 8'h03},
        '{9'h004, 1'b1, 5'h04, 8'h00},
        '{9'h005, 1'b0, 5'h05, 8'h00}
    };

    ebh_if ebh_if_inst();
    ebh_dev ebh_dev_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(ebh_if_inst.dev));
    ebh_ext ebh_ext_inst(.rst_n(hresetn), .wait_cycles(wait_cycles), .ready_pol(ready_pol),
        .hold_req(hold_req), .bus_granted(bus_granted), .bus_wanted(bus_wanted),
        .link(ebh_if_inst.ext));
    ebh_sva ebh_sva_inst(.bus_reference_clock_out(ebh_if_inst.bus_reference_clock_out),
        .hresetn(hresetn), .addr(ebh_if_inst.addr), .ale(ebh_if_inst.ale),
        .rd_n(ebh_if_inst.rd_n), .wr_n(ebh_if_inst.wr_n), .rd_n_oe(ebh_if_inst.rd_n_oe),
        .wr_n_oe(ebh_if_inst.wr_n_oe), .hold_n(ebh_if_inst.hold_n),
        .hold_acknowledge_out_n(ebh_if_inst.hold_acknowledge_out_n),
        .bus_request_out_n(ebh_if_inst.bus_request_out_n));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_val = hrdata;
    endtask

    // Polls the pending flag; running out of polls counts as a mismatch.
    task automatic wait_done();
        int k;
        k = 0;
        do begin
            ahb(EBH_OFS_STATUS, 1'b0, 32'h0);
            k++;
        end while (rd_val[EBH_ST_PEND] !== 1'b0 && k < 100);
        chk("pend clear", 32'h0, {31'h0, rd_val[EBH_ST_PEND]});
    endtask

    task automatic wait_grant(input logic v);
        for (int k = 0; k < 40 && ebh_if_inst.hold_acknowledge_out_n !== v; k++) begin
            @(posedge hclk);
        end
        chk("hold ack", {31'h0, v}, {31'h0, ebh_if_inst.hold_acknowledge_out_n});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    initial begin
        #4000000;
        n_fail++;
        $display("[ERR] watchdog expected end seen hang");
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        hold_req = 1'b0;
        ready_pol = 1'b1;
        wait_cycles = 5'h00;
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            ready_pol <= rows[i].pol;
            wait_cycles <= rows[i].w;
            ahb(EBH_OFS_CTRL, 1'b1, {23'h0, rows[i].ctrl});
            ahb(EBH_OFS_WDATA, 1'b1, 32'h00005a00 | i);
            ahb(EBH_OFS_CMD, 1'b1, (32'h1 << EBH_CMD_WRITE) | i);
            wait_done();
            chk("write waits", {24'h0, rows[i].waits}, {24'h0, rd_val[15:8]});
            ahb(EBH_OFS_CMD, 1'b1, i);
            wait_done();
            chk("read waits", {24'h0, rows[i].waits}, {24'h0, rd_val[15:8]});
            ahb(EBH_OFS_RDATA, 1'b0, 32'h0);
            chk("read data", 32'h00005a00 | i, rd_val);
            $display("row %0d done", i);
        end

        // Second reset in mid-run: link idles and registers clear.
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("ack idle", 32'h1, ebh_if_inst.hold_acknowledge_out_n);
        chk("bus_request_out idle", 32'h1, ebh_if_inst.bus_request_out_n);
        chk("strobes idle", 32'h3, {ebh_if_inst.rd_n, ebh_if_inst.wr_n});
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(EBH_OFS_STATUS, 1'b0, 32'h0);
        chk("status reset", 32'h0, rd_val);
        ahb(EBH_OFS_CTRL, 1'b1, 32'hffffffff);
        ahb(8'h20, 1'b1, 32'hffffffff);
        ahb(8'h20, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd_val);
        ahb(EBH_OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h000001ff, rd_val);
        chk("hresp", 32'h0, hresp);
        $display("reset test done");

        // Hold ignored while arbitration is off.
        ready_pol <= 1'b1;
        ahb(EBH_OFS_CTRL, 1'b1, 32'h005);
        hold_req <= 1'b1;
        ahb(EBH_OFS_CMD, 1'b1, 32'h1);
        wait_done();
        chk("pend arb off", 32'h0, rd_val[EBH_ST_PEND]);
        chk("ack arb off", 32'h1, ebh_if_inst.hold_acknowledge_out_n);
        // Hold raised during a slow cycle: grant only after it ends.
        hold_req <= 1'b0;
        wait_cycles <= 5'h08;
        ahb(EBH_OFS_CTRL, 1'b1, 32'h00d);
        ahb(EBH_OFS_CMD, 1'b1, 32'h2);
        @(posedge hclk);
        hold_req <= 1'b1;
        wait_grant(1'b0);
        ahb(EBH_OFS_STATUS, 1'b0, 32'h0);
        chk("held no pend", 32'h2, rd_val[1:0]);
        chk("granted", 32'h1, bus_granted);
        // Access queued while held raises the bus request.
        ahb(EBH_OFS_WDATA, 1'b1, 32'h00000c3c);
        ahb(EBH_OFS_CMD, 1'b1, 32'h00010003);
        for (int k = 0; k < 20 && ebh_if_inst.bus_request_out_n !== 1'b0; k++) begin
            @(posedge hclk);
        end
        chk("bus_request_out", 32'h0, ebh_if_inst.bus_request_out_n);
        ahb(EBH_OFS_STATUS, 1'b0, 32'h0);
        chk("status held", 32'h7, rd_val[2:0]);
        chk("wanted", 32'h1, bus_wanted);
        chk("pulled up", 32'h3, {ebh_if_inst.rd_n, ebh_if_inst.wr_n});
        hold_req <= 1'b0;
        wait_grant(1'b1);
        chk("bus_request_out dropped", 32'h1, ebh_if_inst.bus_request_out_n);
        wait_done();
        chk("pend after regain", 32'h0, rd_val[EBH_ST_PEND]);
        // Hold withdrawn with no access waiting: no bus request at all.
        hold_req <= 1'b1;
        wait_grant(1'b0);
        repeat (4) @(posedge hclk);
        chk("no bus_request_out", 32'h1, ebh_if_inst.bus_request_out_n);
        hold_req <= 1'b0;
        wait_grant(1'b1);
        chk("regained", 32'h1, ebh_if_inst.hold_acknowledge_out_n);
        @(posedge hclk);
        ahb(EBH_OFS_CMD, 1'b1, 32'h3);
        wait_done();
        ahb(EBH_OFS_RDATA, 1'b0, 32'h0);
        chk("data after regain", 32'h00000c3c, rd_val);
        $display("arbitration test done");
        tally_and_finish();
    end
endmodule
